/* File: core/clpb_pkg.sv */
// Purpose: constants and types of the charger listener parameter bank
// Assumes: 40 MHz system clock, parameter access by 8-bit id
// Notes: parameter ids are local choices
package clpb_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_PS = 25000;
    localparam int THERM_PERIOD_US = 1000;
    localparam int THERM_CYCLES = (THERM_PERIOD_US * 1000000) / CLK_PERIOD_PS;
    // ==========================================================
    // Parameter ids
    localparam logic [7:0] ID_REQ_SEL = 8'h01;
    localparam logic [7:0] ID_DETUNE = 8'h02;
    localparam logic [7:0] ID_CL_EN = 8'h03;
    localparam logic [7:0] ID_FAULT = 8'h04;
    localparam logic [7:0] ID_CHG_STATE = 8'h05;
    localparam logic [7:0] ID_VBAT = 8'h06;
    localparam logic [7:0] ID_VCORE = 8'h07;
    localparam logic [7:0] ID_THERM = 8'h08;
    localparam logic [7:0] ID_OSC = 8'h09;
    localparam logic [7:0] ID_LINK = 8'h0A;
    localparam logic [7:0] ID_THERM_MODE = 8'h0B;
    localparam logic [7:0] ID_RF_FIELD = 8'h0C;
    // ==========================================================
    // Encodings and reset values
    localparam logic [1:0] REQ_BY_CHARGER = 2'h0;
    localparam logic [1:0] REQ_DISABLED = 2'h1;
    localparam logic [1:0] REQ_ALWAYS = 2'h2;
    localparam logic [1:0] RST_REQ_SEL = 2'h0;
    localparam logic RST_DETUNE = 1'h0;
    localparam logic RST_CL_EN = 1'h1;
    localparam logic RST_OSC = 1'h1;
    localparam logic RST_THERM_MODE = 1'h0;
    localparam logic [7:0] FAULT_NONE = 8'h00;
    localparam logic [7:0] FAULT_CHIP_TEMP = 8'h01;
    localparam logic [7:0] FAULT_PROTOCOL = 8'h02;
    localparam logic [7:0] FAULT_NO_BATT = 8'h04;
    localparam logic [7:0] FAULT_BATT_TEMP = 8'h08;
    localparam logic [7:0] FAULT_TRICKLE_TO = 8'h0C;
    localparam logic [7:0] FAULT_CC_TO = 8'h10;
    localparam logic [7:0] FAULT_CV_TO = 8'h14;
    localparam logic [7:0] CHG_DISABLED = 8'h00;
    localparam logic [7:0] CHG_TRICKLE = 8'h01;
    localparam logic [7:0] CHG_CC = 8'h02;
    localparam logic [7:0] CHG_CV = 8'h03;
    localparam logic [7:0] CHG_DONE = 8'h04;
    localparam logic [1:0] LINK_NONE_CODE = 2'h0;
    localparam logic [1:0] LINK_INFO_CODE = 2'h1;
    localparam logic [1:0] LINK_CHG_CODE = 2'h3;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        LINK_NONE = 3'b001,
        LINK_INFO = 3'b010,
        LINK_CHARGING = 3'b100
    } clpb_link_e;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] id;
        logic [7:0] data;
    } clpb_req_s;
    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } clpb_adc_s;
endpackage

/* File: core/clpb_param_bank.sv */
// Purpose: host-visible parameter and status bank of the charger listener
// Assumes: all inputs but the field detector come from logic on clk_sys
// Notes: host accesses are single-cycle strobes, reads answer next cycle
// Function
// - Two-bit select picks request source: charger, disabled, always; default charger.
// - Charger source stops request at full battery; always-select keeps requesting.
// - Written detune bit turns detuning circuitry on at 1, off at 0.
// - Contactless enable at 0 drops every contactless command; at 1 passes them.
// - Fault code 0 none, 1 chip temp, 2 protocol, 4 no battery, 8 battery temp.
// - Trickle, constant-current, constant-voltage timeouts read 0x0C, 0x10, 0x14.
// - Host read of fault code clears it to no error.
// - Charger state byte encodes disabled, trickle, CC, CV, completed as 0..4.
// - Battery voltage byte reports present conversion code, 12.5mV per step plus 2.4V.
// - Core voltage byte uses same encoding and reports current measurement.
// - Voltage byte reads zero whenever converter cannot measure.
// - Oscillator enable bit enables oscillator mode in each power cycle; default on.
// - Link state 00 none, 01 after information record, 11 after first control read.
// - Link state returns to 00 whenever the contactless field disappears.
// - Thermistor refreshed every 1ms with mode 0, once before each cycle with 1.
// - Field off: charger state reads 0, except completed which reads 4.
// - During a power cycle charger state follows internal phase directly.
// - During communication active phases hold last value; disabled 0, completed 4.
// - Field status bit reads 1 while field present, else 0.
`timescale 1ns/100ps
`default_nettype none
module clpb_param_bank
    import clpb_pkg::*;
#(
    parameter int THERM_TICKS = THERM_CYCLES
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Sync reset, low active
    input wire clpb_req_s hostReq, // Host access strobe
    output logic [7:0] hostRdData_q, // Read answer
    output logic hostRdValid_q, // Read answer strobe
    input wire logic rfFieldPin, // Field detector, async
    input wire logic inPowerCycle, // Power transfer cycle active
    input wire logic inCommPhase, // Contactless communication active
    input wire logic powerCycleStart, // Pulse before each power cycle
    input wire logic [7:0] chargerPhase, // Internal charger phase 0..4
    input wire logic chargerWantsPower, // Charger asks for power
    input wire logic batteryFull, // Battery full
    input wire logic faultEvent, // Fault pulse
    input wire logic [7:0] faultEventCode, // Code of that fault
    input wire clpb_adc_s batteryAdc, // Battery conversion
    input wire clpb_adc_s coreAdc, // Core conversion
    input wire logic [7:0] thermistorRaw, // Live thermistor class
    input wire logic pollerInfoWritten, // Information record written
    input wire logic listenerCtlRead, // Control record read
    input wire logic clCmdValid, // Contactless command in
    output logic clCmdAccept_q, // Command passed on
    output logic powerTransferRequest_q, // Power transfer request
    output logic antennaDetune_q, // Detune circuitry on
    output logic oscModeOn_q // Oscillator mode active
);
    // ==========================================================
    // Field detector synchroniser
    logic fieldMeta_q, fieldSync_q;
    always_ff @(posedge clk_sys) begin
        fieldMeta_q <= rst_n ? rfFieldPin : 1'b0;
        fieldSync_q <= rst_n ? fieldMeta_q : 1'b0;
    end

    // ==========================================================
    // Writable control fields
    logic [1:0] reqSel_q, reqSel_d;
    logic detune_d, clEnable_q, clEnable_d, oscCtrl_q, oscCtrl_d, thermMode_q, thermMode_d;
    always_comb begin
        reqSel_d = reqSel_q;
        detune_d = antennaDetune_q;
        clEnable_d = clEnable_q;
        oscCtrl_d = oscCtrl_q;
        thermMode_d = thermMode_q;
        if (hostReq.wr) begin
            case (hostReq.id)
                ID_REQ_SEL: reqSel_d = hostReq.data[1:0];
                ID_DETUNE: detune_d = hostReq.data[0];
                ID_CL_EN: clEnable_d = hostReq.data[0];
                ID_OSC: oscCtrl_d = hostReq.data[0];
                ID_THERM_MODE: thermMode_d = hostReq.data[0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reqSel_q <= RST_REQ_SEL;
            antennaDetune_q <= RST_DETUNE;
            clEnable_q <= RST_CL_EN;
            oscCtrl_q <= RST_OSC;
            thermMode_q <= RST_THERM_MODE;
        end else begin
            reqSel_q <= reqSel_d;
            antennaDetune_q <= detune_d;
            clEnable_q <= clEnable_d;
            oscCtrl_q <= oscCtrl_d;
            thermMode_q <= thermMode_d;
        end
    end

    // ==========================================================
    // Outputs steered by control fields
    logic powerReq_d, clAccept_d, oscOn_d;
    always_comb begin
        case (reqSel_q)
            REQ_BY_CHARGER: powerReq_d = chargerWantsPower && !batteryFull;
            REQ_ALWAYS: powerReq_d = 1'b1;
            default: powerReq_d = 1'b0; // Disabled; reserved treated alike
        endcase
        clAccept_d = clCmdValid && clEnable_q;
        oscOn_d = oscCtrl_q && inPowerCycle;
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            powerTransferRequest_q <= 1'b0;
            clCmdAccept_q <= 1'b0;
            oscModeOn_q <= 1'b0;
        end else begin
            powerTransferRequest_q <= powerReq_d;
            clCmdAccept_q <= clAccept_d;
            oscModeOn_q <= oscOn_d;
        end
    end

    // ==========================================================
    // Fault code, cleared by host read
    logic [7:0] fault_q, fault_d;
    logic faultRead;
    assign faultRead = hostReq.rd && (hostReq.id == ID_FAULT);
    always_comb begin
        fault_d = fault_q;
        if (faultRead) begin
            fault_d = FAULT_NONE;
        end
        // A fault arriving with the read is kept, not lost
        if (faultEvent) begin
            fault_d = faultEventCode;
        end
    end
    always_ff @(posedge clk_sys) begin
        fault_q <= rst_n ? fault_d : FAULT_NONE;
    end

    // ==========================================================
    // Charger state as seen through system state
    logic [7:0] chgState_q, chgState_d;
    always_comb begin
        chgState_d = chgState_q;
        if (chargerPhase == CHG_DONE) begin
            chgState_d = CHG_DONE;
        end else if (!fieldSync_q || chargerPhase == CHG_DISABLED) begin
            chgState_d = CHG_DISABLED;
        end else if (inPowerCycle) begin
            chgState_d = chargerPhase;
        end else if (!inCommPhase) begin
            chgState_d = chargerPhase; // Field up, idle: follow phase
        end
        // During communication active phases hold their value
    end
    always_ff @(posedge clk_sys) begin
        chgState_q <= rst_n ? chgState_d : CHG_DISABLED;
    end

    // ==========================================================
    // Node voltage codes, zero when not measurable
    logic [7:0] vbat_q, vbat_d, vcore_q, vcore_d;
    always_comb begin
        vbat_d = batteryAdc.valid ? batteryAdc.code : READ_ZERO;
        vcore_d = coreAdc.valid ? coreAdc.code : READ_ZERO;
    end
    always_ff @(posedge clk_sys) begin
        vbat_q <= rst_n ? vbat_d : READ_ZERO;
        vcore_q <= rst_n ? vcore_d : READ_ZERO;
    end

    // ==========================================================
    // Thermistor sampling; slow tick trades area for a wide counter
    logic [31:0] thermCnt_q, thermCnt_d;
    logic [7:0] therm_q, therm_d;
    logic thermTick;
    assign thermTick = (thermCnt_q == 32'(THERM_TICKS - 1));
    always_comb begin
        thermCnt_d = thermTick ? 32'h0 : thermCnt_q + 32'h1;
        therm_d = therm_q;
        if (thermMode_q ? powerCycleStart : thermTick) begin
            therm_d = thermistorRaw;
        end
    end
    always_ff @(posedge clk_sys) begin
        thermCnt_q <= rst_n ? thermCnt_d : 32'h0;
        therm_q <= rst_n ? therm_d : READ_ZERO;
    end

    // ==========================================================
    // Poller link state
    clpb_link_e link_q, link_d;
    logic [1:0] linkCode;
    always_comb begin
        link_d = link_q;
        case (link_q)
            LINK_NONE: if (pollerInfoWritten) link_d = LINK_INFO;
            LINK_INFO: if (listenerCtlRead) link_d = LINK_CHARGING;
            LINK_CHARGING: link_d = LINK_CHARGING;
            default: link_d = LINK_NONE;
        endcase
        if (!fieldSync_q) begin
            link_d = LINK_NONE;
        end
        case (link_q)
            LINK_INFO: linkCode = LINK_INFO_CODE;
            LINK_CHARGING: linkCode = LINK_CHG_CODE;
            default: linkCode = LINK_NONE_CODE;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        link_q <= rst_n ? link_d : LINK_NONE;
    end

    // ==========================================================
    // Read path; write-only and unknown ids answer zero
    logic [7:0] rdData_d;
    always_comb begin
        case (hostReq.id)
            ID_FAULT: rdData_d = fault_q;
            ID_CHG_STATE: rdData_d = chgState_q;
            ID_VBAT: rdData_d = vbat_q;
            ID_VCORE: rdData_d = vcore_q;
            ID_THERM: rdData_d = therm_q;
            ID_LINK: rdData_d = {6'h00, linkCode};
            ID_RF_FIELD: rdData_d = {7'h00, fieldSync_q};
            default: rdData_d = READ_ZERO;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hostRdData_q <= READ_ZERO;
            hostRdValid_q <= 1'b0;
        end else begin
            hostRdData_q <= hostReq.rd ? rdData_d : hostRdData_q;
            hostRdValid_q <= hostReq.rd;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_infoSeen; link_q == LINK_NONE && pollerInfoWritten && fieldSync_q; endsequence
    sequence s_ctlSeen; listenerCtlRead && fieldSync_q; endsequence
    a_req_always: assert property (reqSel_q == REQ_ALWAYS |=> powerTransferRequest_q)
        else $error("request dropped with always select");
    a_req_full: assert property (reqSel_q == REQ_BY_CHARGER && batteryFull |=> !powerTransferRequest_q)
        else $error("request held with battery full");
    a_req_off: assert property (reqSel_q == REQ_DISABLED |=> !powerTransferRequest_q)
        else $error("request with select disabled");
    a_detune_write: assert property (hostReq.wr && hostReq.id == ID_DETUNE |=> antennaDetune_q == $past(hostReq.data[0]))
        else $error("detune bit not taken");
    a_cl_gate: assert property (!clEnable_q |=> !clCmdAccept_q)
        else $error("command passed while disabled");
    a_fault_clear: assert property (faultRead && !faultEvent |=> fault_q == FAULT_NONE)
        else $error("fault not cleared by read");
    a_fault_read: assert property (faultRead ##1 1 |-> hostRdValid_q && hostRdData_q == $past(fault_q))
        else $error("fault read returned wrong value");
    a_adc_zero: assert property (!batteryAdc.valid |=> vbat_q == READ_ZERO)
        else $error("battery code not zero");
    a_link_drop: assert property (!fieldSync_q |=> link_q == LINK_NONE)
        else $error("link state kept without field");
    // Link walks 00, 01, 11 one step per record event, so each step is checked alone
    a_link_steps: assert property (s_infoSeen |=> link_q == LINK_INFO)
        else $error("link did not reach info");
    a_link_charge: assert property (link_q == LINK_INFO ##0 s_ctlSeen |=> link_q == LINK_CHARGING)
        else $error("link did not reach charging");
    // Request and gates follow their sources one cycle late
    a_req_charger: assert property (reqSel_q == REQ_BY_CHARGER
        && chargerWantsPower && !batteryFull |=> powerTransferRequest_q)
        else $error("request missing with charger select");
    a_cl_pass: assert property (clEnable_q && clCmdValid |=> clCmdAccept_q)
        else $error("command dropped while enabled");
    a_osc_gate: assert property (oscCtrl_q && inPowerCycle |=> oscModeOn_q)
        else $error("oscillator mode missing in power cycle");
    // Fault and voltage bytes take the new value in the next cycle
    a_fault_set: assert property (faultEvent |=> fault_q == $past(faultEventCode))
        else $error("fault code not captured");
    a_core_zero: assert property (!coreAdc.valid |=> vcore_q == READ_ZERO)
        else $error("core code not zero");
    a_vbat_code: assert property (batteryAdc.valid |=> vbat_q == $past(batteryAdc.code))
        else $error("battery code not reported");
    a_vcore_code: assert property (coreAdc.valid |=> vcore_q == $past(coreAdc.code))
        else $error("core code not reported");
    a_chg_done: assert property (chargerPhase == CHG_DONE |=> chgState_q == CHG_DONE)
        else $error("completed phase not reported");
    a_chg_follow: assert property (fieldSync_q && inPowerCycle |=> chgState_q == $past(chargerPhase))
        else $error("charger state not following phase");
    a_field_read: assert property (hostReq.rd && hostReq.id == ID_RF_FIELD
        |=> hostRdData_q == {7'h00, $past(fieldSync_q)})
        else $error("field status read wrong");
    a_therm_tick: assert property (!thermMode_q && thermTick |=> therm_q == $past(thermistorRaw))
        else $error("thermistor not refreshed on tick");
    a_chg_off: assert property (!fieldSync_q && chargerPhase != CHG_DONE |=> chgState_q == CHG_DISABLED)
        else $error("charger state not zero without field");
    a_chg_hold: assert property (fieldSync_q && inCommPhase && !inPowerCycle && chargerPhase != CHG_DONE
        && chargerPhase != CHG_DISABLED |=> $stable(chgState_q))
        else $error("charger state moved in communication");
    a_therm_mode: assert property (thermMode_q && !powerCycleStart |=> $stable(therm_q))
        else $error("thermistor refreshed outside cycle start");
endmodule
`default_nettype wire

/* File: verif/clpb_host_model.sv */
// Purpose: host microcontroller model for the parameter bank
// Assumes: requests launched just after the falling edge of clk_sys
// Notes: idle id and data lines show a changing pattern, never the last value
`timescale 1ns/100ps
`default_nettype none
module clpb_host_model
    import clpb_pkg::*;
(
    input wire logic clk_sys, // System clock
    output var clpb_req_s hostReq, // Host access strobe
    input wire logic [7:0] hostRdData_q, // Read answer
    input wire logic hostRdValid_q // Read answer strobe
);
    // ==========================================================
    // Bus tasks
    initial begin
        hostReq = '0;
    end
    // Inverted lines so a stale id or data can never pass as valid
    task automatic release_bus();
        hostReq.wr = 1'b0;
        hostReq.rd = 1'b0;
        hostReq.id = ~hostReq.id;
        hostReq.data = ~hostReq.data;
    endtask
    // One-cycle write strobe, no answer
    task automatic wr(input logic [7:0] id, input logic [7:0] data);
        @(negedge clk_sys);
        hostReq = '{wr: 1'b1, rd: 1'b0, id: id, data: data};
        @(negedge clk_sys);
        release_bus();
    endtask
    // Answer strobe stands one cycle, so it is taken in that cycle
    task automatic rd(input logic [7:0] id, output logic [7:0] data, output logic ok);
        @(negedge clk_sys);
        hostReq = '{wr: 1'b0, rd: 1'b1, id: id, data: 8'h00};
        @(negedge clk_sys);
        data = hostRdData_q;
        ok = hostRdValid_q;
        release_bus();
    endtask
endmodule
`default_nettype wire

/* File: verif/clpb_param_bank_test.sv */
// Purpose: self-checking bench of the parameter bank
// Assumes: thermistor period shortened to 20 cycles
// Notes: inputs change at the falling edge
`timescale 1ns/100ps
`default_nettype none
module clpb_param_bank_test
    import clpb_pkg::*;
;
    localparam int TICKS = 20;
    logic clk_sys, rst_n, rfFieldPin, inPowerCycle, inCommPhase, powerCycleStart;
    logic chargerWantsPower, batteryFull, faultEvent, pollerInfoWritten, listenerCtlRead, clCmdValid;
    logic [7:0] chargerPhase, faultEventCode, thermistorRaw, hostRdData_q, last, raw;
    logic hostRdValid_q, clCmdAccept_q, powerTransferRequest_q, antennaDetune_q, oscModeOn_q;
    clpb_adc_s batteryAdc, coreAdc;
    clpb_req_s hostReq;
    int err_count, num_checks, cycles;
    integer seed;
    logic [7:0] wo[6] = '{ID_REQ_SEL, ID_DETUNE, ID_CL_EN, ID_OSC, ID_THERM_MODE, 8'hFF};
    logic [7:0] codes[7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    // ==========================================================
    // Design, host and clock
    clpb_param_bank #(.THERM_TICKS(TICKS)) clpb_param_bank_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .hostReq(hostReq), .hostRdData_q(hostRdData_q), .hostRdValid_q(hostRdValid_q),
        .rfFieldPin(rfFieldPin), .inPowerCycle(inPowerCycle), .inCommPhase(inCommPhase),
        .powerCycleStart(powerCycleStart), .chargerPhase(chargerPhase),
        .chargerWantsPower(chargerWantsPower), .batteryFull(batteryFull), .faultEvent(faultEvent),
        .faultEventCode(faultEventCode), .batteryAdc(batteryAdc), .coreAdc(coreAdc),
        .thermistorRaw(thermistorRaw), .pollerInfoWritten(pollerInfoWritten),
        .listenerCtlRead(listenerCtlRead), .clCmdValid(clCmdValid), .clCmdAccept_q(clCmdAccept_q),
        .powerTransferRequest_q(powerTransferRequest_q), .antennaDetune_q(antennaDetune_q),
        .oscModeOn_q(oscModeOn_q));
    clpb_host_model clpb_host_model_i (.clk_sys(clk_sys), .hostReq(hostReq),
        .hostRdData_q(hostRdData_q), .hostRdValid_q(hostRdValid_q));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // ==========================================================
    // Helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // A missing answer strobe poisons the data so the compare fails
    task automatic rdChk(input logic [7:0] id, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        clpb_host_model_i.rd(id, d, ok);
        if (ok !== 1'b1) d = 8'hXX;
        chk(d, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask
    task automatic setState(input int st);
        rfFieldPin = (st != 0);
        inPowerCycle = (st == 1);
        inCommPhase = (st == 2);
    endtask
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic logic expReq(input logic [1:0] sel, input logic wants, input logic full);
        case (sel)
            REQ_BY_CHARGER: return wants & ~full;
            REQ_ALWAYS: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    // State 0 field off, 1 power cycle, 2 communication
    function automatic logic [7:0] expChg(input int st, input logic [7:0] ph, input logic [7:0] lst);
        if (ph == CHG_DONE) return CHG_DONE;
        if (ph == CHG_DISABLED || st == 0) return CHG_DISABLED;
        return (st == 2) ? lst : ph;
    endfunction
    // Hang guard, well above the expected run length
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_sim();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        seed = 32'h39aba85f;
        {rst_n, rfFieldPin, inPowerCycle, inCommPhase, powerCycleStart, chargerWantsPower} = '0;
        {batteryFull, faultEvent, pollerInfoWritten, listenerCtlRead, clCmdValid} = '0;
        {chargerPhase, faultEventCode, thermistorRaw} = '0;
        batteryAdc = '0;
        coreAdc = '0;
        settle(2);
        rst_n = 1'b1;
        foreach (wo[i]) rdChk(wo[i], READ_ZERO);
        foreach (codes[i]) rdChk(8'(ID_FAULT + i), READ_ZERO);
        clCmdValid = 1'b1;
        inPowerCycle = 1'b1;
        chargerWantsPower = 1'b1;
        settle(2);
        chk({7'h00, clCmdAccept_q}, 8'h01);
        chk({7'h00, oscModeOn_q}, 8'h01);
        chk({7'h00, powerTransferRequest_q}, 8'h01);
        $display("test reset done");
        // Every select code, full battery forced on the first trial
        for (int s = 0; s < 4; s++) begin
            clpb_host_model_i.wr(ID_REQ_SEL, 8'(s));
            for (int k = 0; k < 4; k++) begin
                chargerWantsPower = (k == 0) | 1'($random(seed));
                batteryFull = (k == 0) | 1'($random(seed));
                settle(2);
                chk({7'h00, powerTransferRequest_q}, {7'h00, expReq(2'(s), chargerWantsPower, batteryFull)});
            end
        end
        $display("test request done");
        for (int k = 0; k < 2; k++) begin
            clpb_host_model_i.wr(ID_DETUNE, 8'(k));
            clpb_host_model_i.wr(ID_CL_EN, 8'(k));
            clpb_host_model_i.wr(ID_OSC, 8'(k));
            settle(2);
            chk({7'h00, antennaDetune_q}, 8'(k));
            chk({7'h00, clCmdAccept_q}, 8'(k));
            chk({7'h00, oscModeOn_q}, 8'(k));
        end
        $display("test enables done");
        foreach (codes[i]) begin
            faultEventCode = codes[i];
            pulse(faultEvent);
            rdChk(ID_FAULT, codes[i]);
            rdChk(ID_FAULT, FAULT_NONE);
        end
        $display("test fault done");
        for (int k = 0; k < 8; k++) begin
            batteryAdc = '{valid: (k != 0) & 1'($random(seed)), code: 8'($random(seed))};
            coreAdc = '{valid: (k != 1) & 1'($random(seed)), code: 8'($random(seed))};
            settle(2);
            rdChk(ID_VBAT, batteryAdc.valid ? batteryAdc.code : READ_ZERO);
            rdChk(ID_VCORE, coreAdc.valid ? coreAdc.code : READ_ZERO);
        end
        $display("test voltage done");
        // Each system state against each phase, last value seeded first
        for (int st = 0; st < 3; st++) begin
            for (int p = 0; p < 5; p++) begin
                last = 8'(1 + {$random(seed)} % 3);
                setState(1);
                chargerPhase = last;
                settle(5);
                rdChk(ID_CHG_STATE, last);
                setState(st);
                chargerPhase = 8'(p);
                settle(5);
                rdChk(ID_CHG_STATE, expChg(st, 8'(p), last));
                rdChk(ID_RF_FIELD, 8'(st != 0));
            end
        end
        $display("test charger done");
        setState(2);
        settle(4);
        pulse(pollerInfoWritten);
        rdChk(ID_LINK, 8'h01);
        pulse(listenerCtlRead);
        rdChk(ID_LINK, 8'h03);
        setState(0);
        settle(4);
        rdChk(ID_LINK, 8'h00);
        $display("test link done");
        raw = 8'($random(seed));
        thermistorRaw = raw;
        settle(TICKS + 4);
        rdChk(ID_THERM, raw);
        clpb_host_model_i.wr(ID_THERM_MODE, 8'h01);
        thermistorRaw = ~raw;
        settle(2 * TICKS + 4);
        rdChk(ID_THERM, raw);
        pulse(powerCycleStart);
        settle(2);
        rdChk(ID_THERM, ~raw);
        $display("test thermistor done");
        end_sim();
    end
endmodule
`default_nettype wire
